/* File: verilog/servo_io_function_logic.sv */
`include "servo_io_defs.svh"

module servo_io_function_logic
	import servo_io_pkg::*;
(
	// clock and reset
	input  wire  logic               core_clk,
	input  wire  logic               sys_rst,
	input  wire  logic               clk_en,
	// avalon-mm slave
	input  wire  logic [6:0]         avs_address,
	input  wire  logic               avs_read,
	input  wire  logic               avs_write,
	input  wire  logic [31:0]        avs_writedata,
	output logic       [31:0]        avs_readdata,
	output logic                     avs_waitrequest,
	// digital input functions
	input  wire  logic               emergency_halt_in,
	input  wire  logic               clear_deviation_in,
	input  wire  logic               speed_limit_source_sel,
	input  wire  logic               pulse_cmd_block,
	input  wire  logic               origin_capture_in,
	input  wire  logic [1:0]         preset_speed_sel,
	input  wire  logic [1:0]         preset_torque_sel,
	input  wire  logic               prop_only_loop_in,
	// drive state
	input  wire  logic               power_ok_in,
	input  wire  logic               fault_in,
	input  wire  logic               servo_on_in,
	// command and feedback
	input  wire  logic               cmd_pulse_in,
	input  wire  logic               cmd_dir_in,
	input  wire  logic               fb_pulse_in,
	input  wire  logic               fb_dir_in,
	input  wire  logic signed [15:0] speed_cmd_in,
	input  wire  logic signed [15:0] motor_speed_in,
	input  wire  logic signed [15:0] filt_speed_in,
	input  wire  logic signed [15:0] speed_ref_in,
	// loop controls
	output logic signed [15:0]       drive_speed_out,
	output logic                     position_lock_out,
	output logic       [15:0]        speed_limit_out,
	output logic       [15:0]        preset_speed_out,
	output logic       [15:0]        preset_torque_out,
	output logic                     p_only_loop_out,
	// digital output functions
	output logic                     ready_out,
	output logic                     rotation_detect_out,
	output logic                     zero_speed_out,
	output logic                     speed_match_out,
	output logic                     position_done_out
);
	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [2:0]  ctrl_q, ctrl_d;
	logic [15:0] lim_q [2];
	logic [15:0] lim_d [2];
	logic [15:0] spd_q [4];
	logic [15:0] spd_d [4];
	logic [15:0] trq_q [4];
	logic [15:0] trq_d [4];
	logic [15:0] band_q [4];
	logic [15:0] band_d [4];
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wr_go;
	mode_t       mode;
	logic        pulse_src;

	assign mode      = mode_t'(ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	assign pulse_src = ~ctrl_q[`CTRL_PSRC_BIT];
	assign wr_go     = avs_write & ack_q; // write lands at the acknowledge edge

	// one wait cycle per access, then acknowledge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata    = rdata_q;

	// ----------------------------------------
	// position counters and halt sequencer
	// ----------------------------------------
	logic signed [31:0] dev_q, dev_d;
	logic signed [31:0] fb_pos_q, fb_pos_d;
	logic signed [31:0] origin_q, origin_d;
	logic signed [31:0] rel_pos;
	halt_state_t        halt_q, halt_d;
	logic signed [15:0] spd_out_q, spd_out_d;
	logic               ready_q, ready_d;
	logic [15:0]        slim_q, slim_d;
	logic [15:0]        pspd_q, pspd_d;
	logic [15:0]        ptrq_q, ptrq_d;
	logic               ponly_q, ponly_d;
	logic               cmd_take;

	assign rel_pos = fb_pos_q - origin_q;

	// status word for readback
	logic [31:0] status_word;
	status_cmp_if cif ();
	assign status_word = {24'h000000, halt_q, rotation_detect_out, zero_speed_out,
		speed_match_out, position_done_out, ready_q};

	// register writes and read mux
	always_comb begin
		ctrl_d  = ctrl_q;
		lim_d   = lim_q;
		spd_d   = spd_q;
		trq_d   = trq_q;
		band_d  = band_q;
		ack_d   = (avs_read | avs_write) & ~ack_q;
		rdata_d = rdata_q;
		if (wr_go) begin
			unique case (avs_address)
				`OFS_CTRL:       ctrl_d    = avs_writedata[2:0];
				`OFS_LIM_SRC0:   lim_d[0]  = avs_writedata[15:0];
				`OFS_LIM_SRC1:   lim_d[1]  = avs_writedata[15:0];
				`OFS_ROT_THR:    band_d[0] = avs_writedata[15:0];
				`OFS_ZERO_BAND:  band_d[1] = avs_writedata[15:0];
				`OFS_MATCH_BAND: band_d[2] = avs_writedata[15:0];
				`OFS_DONE_RANGE: band_d[3] = avs_writedata[15:0];
				default: begin
					if (avs_address[6:4] == 3'h1)
						spd_d[avs_address[3:2]] = avs_writedata[15:0];
					else if (avs_address[6:4] == 3'h2)
						trq_d[avs_address[3:2]] = avs_writedata[15:0];
				end
			endcase
		end
		if (avs_read & ~ack_q) begin
			unique case (avs_address)
				`OFS_CTRL:       rdata_d = {29'h0, ctrl_q};
				`OFS_STATUS:     rdata_d = status_word;
				`OFS_LIM_SRC0:   rdata_d = {16'h0, lim_q[0]};
				`OFS_LIM_SRC1:   rdata_d = {16'h0, lim_q[1]};
				`OFS_ROT_THR:    rdata_d = {16'h0, band_q[0]};
				`OFS_ZERO_BAND:  rdata_d = {16'h0, band_q[1]};
				`OFS_MATCH_BAND: rdata_d = {16'h0, band_q[2]};
				`OFS_DONE_RANGE: rdata_d = {16'h0, band_q[3]};
				`OFS_DEVIATION:  rdata_d = dev_q;
				`OFS_POSITION:   rdata_d = rel_pos;
				default: begin
					if (avs_address[6:4] == 3'h1)
						rdata_d = {16'h0, spd_q[avs_address[3:2]]};
					else if (avs_address[6:4] == 3'h2)
						rdata_d = {16'h0, trq_q[avs_address[3:2]]};
					else
						rdata_d = 32'h00000000;
				end
			endcase
		end
	end

	// register file storage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_q  <= `RST_CTRL;
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else if (clk_en) begin
			ctrl_q  <= ctrl_d;
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// parameter arrays, one loop per entry
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_param
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					spd_q[gi]  <= `RST_PARAM;
					trq_q[gi]  <= `RST_PARAM;
					band_q[gi] <= `RST_PARAM;
				end else if (clk_en) begin
					spd_q[gi]  <= spd_d[gi];
					trq_q[gi]  <= trq_d[gi];
					band_q[gi] <= band_d[gi];
				end
			end
			// two limit registers, one process each
			if (gi < 2) begin : g_lim
				always_ff @(posedge core_clk) begin
					if (sys_rst)
						lim_q[gi] <= `RST_PARAM;
					else if (clk_en)
						lim_q[gi] <= lim_d[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// input functions
	// ----------------------------------------
	assign cmd_take = cmd_pulse_in & (mode == MODE_POS) & pulse_src
		& ~pulse_cmd_block & (halt_q == HALT_RUN);

	// deviation, feedback position, origin
	always_comb begin
		dev_d    = dev_q;
		fb_pos_d = fb_pos_q;
		origin_d = origin_q;
		if (cmd_take)
			dev_d = cmd_dir_in ? dev_d - 32'sd1 : dev_d + 32'sd1;
		if (fb_pulse_in) begin
			dev_d    = fb_dir_in ? dev_d + 32'sd1 : dev_d - 32'sd1;
			fb_pos_d = fb_dir_in ? fb_pos_q - 32'sd1 : fb_pos_q + 32'sd1;
		end
		if (clear_deviation_in && mode == MODE_POS)
			dev_d = 32'sd0;
		if (origin_capture_in && mode == MODE_POS)
			origin_d = fb_pos_q;
	end

	// halt sequencer and speed demand
	always_comb begin
		halt_d    = halt_q;
		spd_out_d = spd_out_q;
		unique case (halt_q)
			HALT_RUN: begin
				spd_out_d = speed_cmd_in;
				if (emergency_halt_in)
					halt_d = HALT_DECEL;
			end
			HALT_DECEL: begin
				if (spd_out_q > $signed(`DECEL_STEP))
					spd_out_d = spd_out_q - $signed(`DECEL_STEP);
				else if (spd_out_q < -$signed(`DECEL_STEP))
					spd_out_d = spd_out_q + $signed(`DECEL_STEP);
				else begin
					spd_out_d = 16'sd0;
					halt_d    = HALT_LOCKED;
				end
			end
			HALT_LOCKED: begin
				spd_out_d = 16'sd0;
				if (!emergency_halt_in)
					halt_d = HALT_RUN;
			end
		endcase
	end

	// mode-qualified selections and ready
	always_comb begin
		slim_d  = (mode == MODE_SPD) ? lim_q[speed_limit_source_sel] : slim_q;
		pspd_d  = (mode == MODE_SPD) ? spd_q[preset_speed_sel] : pspd_q;
		ptrq_d  = (mode == MODE_TRQ) ? trq_q[preset_torque_sel] : ptrq_q;
		ponly_d = (mode == MODE_SPD) & prop_only_loop_in;
		ready_d = power_ok_in & ~fault_in & ~servo_on_in & (halt_q == HALT_RUN);
	end

	// control state registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dev_q     <= 32'sd0;
			fb_pos_q  <= 32'sd0;
			origin_q  <= 32'sd0;
			halt_q    <= HALT_RUN;
			spd_out_q <= 16'sd0;
			slim_q    <= `RST_PARAM;
			pspd_q    <= `RST_PARAM;
			ptrq_q    <= `RST_PARAM;
			ponly_q   <= 1'b0;
			ready_q   <= 1'b0;
		end else if (clk_en) begin
			dev_q     <= dev_d;
			fb_pos_q  <= fb_pos_d;
			origin_q  <= origin_d;
			halt_q    <= halt_d;
			spd_out_q <= spd_out_d;
			slim_q    <= slim_d;
			pspd_q    <= pspd_d;
			ptrq_q    <= ptrq_d;
			ponly_q   <= ponly_d;
			ready_q   <= ready_d;
		end
	end

	// ----------------------------------------
	// status comparators
	// ----------------------------------------
	assign cif.mode        = mode;
	assign cif.motor_speed = motor_speed_in;
	assign cif.filt_speed  = filt_speed_in;
	assign cif.speed_ref   = speed_ref_in;
	assign cif.speed_cmd   = speed_cmd_in;
	assign cif.deviation   = dev_q;
	assign cif.rot_thr     = band_q[0];
	assign cif.zero_band   = band_q[1];
	assign cif.match_band  = band_q[2];
	assign cif.done_range  = band_q[3];

	status_compare u_cmp (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.cif      (cif.cmp)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign drive_speed_out     = spd_out_q;
	assign position_lock_out   = (halt_q == HALT_LOCKED);
	assign speed_limit_out     = slim_q;
	assign preset_speed_out    = pspd_q;
	assign preset_torque_out   = ptrq_q;
	assign p_only_loop_out     = ponly_q;
	assign ready_out           = ready_q;
	assign rotation_detect_out = cif.rotating;
	assign zero_speed_out      = cif.zero_speed;
	assign speed_match_out     = cif.speed_match;
	assign position_done_out   = cif.pos_done;
endmodule : servo_io_function_logic

/* File: verilog/servo_io_defs.svh */
`ifndef SERVO_IO_DEFS_SVH
`define SERVO_IO_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL        7'h00
`define OFS_STATUS      7'h04
`define OFS_LIM_SRC0    7'h08
`define OFS_LIM_SRC1    7'h0C
`define OFS_SPD_BASE    7'h10
`define OFS_TRQ_BASE    7'h20
`define OFS_ROT_THR     7'h30
`define OFS_ZERO_BAND   7'h34
`define OFS_MATCH_BAND  7'h38
`define OFS_DONE_RANGE  7'h3C
`define OFS_DEVIATION   7'h40
`define OFS_POSITION    7'h44

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_PSRC_BIT   2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_CTRL        3'h0
`define RST_PARAM       16'h0000
`define DECEL_STEP      16'h0010

`endif

/* File: verilog/servo_io_pkg.sv */
package servo_io_pkg;
	// control mode codes held in the control register
	typedef enum logic [1:0] {
		MODE_POS = 2'h0,
		MODE_SPD = 2'h1,
		MODE_TRQ = 2'h2,
		MODE_RSV = 2'h3
	} mode_t;

	// emergency halt sequencer, one-hot
	typedef enum logic [2:0] {
		HALT_RUN    = 3'b001,
		HALT_DECEL  = 3'b010,
		HALT_LOCKED = 3'b100
	} halt_state_t;
endpackage : servo_io_pkg

/* File: verilog/status_cmp_if.sv */
interface status_cmp_if;
	import servo_io_pkg::*;
	// measurements and limits
	mode_t              mode;
	logic signed [15:0] motor_speed;
	logic signed [15:0] filt_speed;
	logic signed [15:0] speed_ref;
	logic signed [15:0] speed_cmd;
	logic signed [31:0] deviation;
	logic        [15:0] rot_thr;
	logic        [15:0] zero_band;
	logic        [15:0] match_band;
	logic        [15:0] done_range;
	// registered results
	logic               rotating;
	logic               zero_speed;
	logic               speed_match;
	logic               pos_done;

	modport src (output mode, motor_speed, filt_speed, speed_ref, speed_cmd, deviation,
		rot_thr, zero_band, match_band, done_range,
		input rotating, zero_speed, speed_match, pos_done);
	modport cmp (input mode, motor_speed, filt_speed, speed_ref, speed_cmd, deviation,
		rot_thr, zero_band, match_band, done_range,
		output rotating, zero_speed, speed_match, pos_done);
endinterface : status_cmp_if

/* File: verilog/status_compare.sv */
module status_compare
	import servo_io_pkg::*;
(
	// clocking
	input  wire logic   core_clk,
	input  wire logic   sys_rst,
	input  wire logic   clk_en,
	// compare channel
	status_cmp_if.cmp   cif
);
	logic        rot_q, rot_d;
	logic        zero_q, zero_d;
	logic        match_q, match_d;
	logic        done_q, done_d;
	logic [16:0] abs_filt;
	logic [16:0] abs_zero;
	logic [16:0] abs_match;
	logic [31:0] abs_dev;
	logic signed [16:0] dz;
	logic signed [16:0] dm;

	// magnitudes and comparisons
	always_comb begin
		dz        = 17'(cif.motor_speed) - 17'(cif.speed_ref);
		dm        = 17'(cif.motor_speed) - 17'(cif.speed_cmd);
		abs_filt  = cif.filt_speed[15] ? 17'(-17'(cif.filt_speed)) : 17'(cif.filt_speed);
		abs_zero  = dz[16] ? 17'(-dz) : 17'(dz);
		abs_match = dm[16] ? 17'(-dm) : 17'(dm);
		abs_dev   = cif.deviation[31] ? 32'(-cif.deviation) : 32'(cif.deviation);
		rot_d     = abs_filt >= 17'(cif.rot_thr);
		zero_d    = abs_zero <= 17'(cif.zero_band);
		match_d   = (cif.mode == MODE_SPD) && (abs_match < 17'(cif.match_band));
		done_d    = (cif.mode == MODE_POS) && (abs_dev <= 32'(cif.done_range));
	end

	// registered status levels
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rot_q   <= 1'b0;
			zero_q  <= 1'b0;
			match_q <= 1'b0;
			done_q  <= 1'b0;
		end else if (clk_en) begin
			rot_q   <= rot_d;
			zero_q  <= zero_d;
			match_q <= match_d;
			done_q  <= done_d;
		end
	end

	assign cif.rotating    = rot_q;
	assign cif.zero_speed  = zero_q;
	assign cif.speed_match = match_q;
	assign cif.pos_done    = done_q;
endmodule : status_compare

/* File: testbench/host_pulse_src.sv */
// ----------------------------------------
// host pulse train source
// ----------------------------------------
module host_pulse_src (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// request
	input wire logic go,
	input wire logic [7:0] n,
	// pulse line
	output logic pulse,
	output logic busy
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt_q, cnt_d;
	logic pls_q, pls_d;

	// one-cycle pulses, one idle cycle between them
	always_comb begin
		pls_d = cnt_q != 8'h0 && !pls_q;
		cnt_d = pls_d ? cnt_q - 8'h1 : cnt_q;
		if (go) begin
			cnt_d = n;
			pls_d = 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		cnt_q <= sys_rst ? 8'h0 : cnt_d;
		pls_q <= sys_rst ? 1'b0 : pls_d;
	end
	assign pulse = pls_q;
	assign busy = pls_q || cnt_q != 8'h0;
endmodule : host_pulse_src

/* File: testbench/servo_io_chk.sv */
`include "servo_io_defs.svh"

// ----------------------------------------
// port checker
// ----------------------------------------
module servo_io_chk
	import servo_io_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// bus writes
	input wire logic [6:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	// input functions
	input wire logic emergency_halt_in,
	input wire logic speed_limit_source_sel,
	input wire logic [1:0] preset_speed_sel,
	input wire logic [1:0] preset_torque_sel,
	input wire logic prop_only_loop_in,
	input wire logic power_ok_in,
	input wire logic fault_in,
	input wire logic servo_on_in,
	input wire logic signed [15:0] filt_speed_in,
	// outputs
	input wire logic signed [15:0] drive_speed_out,
	input wire logic position_lock_out,
	input wire logic [15:0] speed_limit_out,
	input wire logic [15:0] preset_speed_out,
	input wire logic [15:0] preset_torque_out,
	input wire logic p_only_loop_out,
	input wire logic ready_out,
	input wire logic rotation_detect_out,
	input wire logic speed_match_out,
	input wire logic position_done_out
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [16:0] STEP = {1'b0, `DECEL_STEP};
	logic [15:0] shd_q [32];
	logic [15:0] shd_d [32];
	logic live_q, live_d;
	wire [1:0] md = shd_q[0][1:0];

	function automatic logic [16:0] mag(input logic signed [15:0] v);
		logic signed [16:0] w;
		w = v;
		return w[16] ? 17'(-w) : 17'(w);
	endfunction : mag

	// shadow of completed register writes
	always_comb begin
		shd_d = shd_q;
		live_d = !sys_rst && clk_en;
		if (clk_en && avs_write && !avs_waitrequest) begin
			shd_d[avs_address[6:2]] = avs_writedata[15:0];
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shd_q <= '{default: 16'h0};
		end else begin
			shd_q <= shd_d;
		end
		live_q <= live_d;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_halt_ramp: assert property (live_q && $past(live_q) && $past(emergency_halt_in, 2)
		&& $past(emergency_halt_in) |-> mag(drive_speed_out) == (mag($past(drive_speed_out))
		> STEP ? mag($past(drive_speed_out)) - STEP : 17'h0)) else $error("halt ramp wrong");
	a_ready_cond: assert property (live_q && $past(live_q) |-> ready_out ==
		($past(power_ok_in && !fault_in && !servo_on_in) && !$past(emergency_halt_in, 2)))
		else $error("ready level wrong");
	a_limit_pick: assert property (live_q |-> speed_limit_out == ($past(md == MODE_SPD) ?
		$past(speed_limit_source_sel ? shd_q[3] : shd_q[2]) : $past(speed_limit_out)))
		else $error("speed limit wrong");
	a_speed_code: assert property (live_q |-> preset_speed_out == ($past(md == MODE_SPD) ?
		$past(shd_q[5'h4 + 5'(preset_speed_sel)]) : $past(preset_speed_out)))
		else $error("speed preset wrong");
	a_torque_code: assert property (live_q |-> preset_torque_out == ($past(md == MODE_TRQ) ?
		$past(shd_q[5'h8 + 5'(preset_torque_sel)]) : $past(preset_torque_out)))
		else $error("torque preset wrong");
	a_p_only: assert property (live_q |->
		p_only_loop_out == $past(md == MODE_SPD && prop_only_loop_in)) else $error("loop kind wrong");
	a_rot_thresh: assert property (live_q |-> rotation_detect_out ==
		($past(mag(filt_speed_in)) >= $past({1'b0, shd_q[12]}))) else $error("rotation wrong");
	a_match_mode: assert property (speed_match_out |-> $past(md == MODE_SPD))
		else $error("match outside speed mode");
	a_done_mode: assert property (position_done_out |-> $past(md == MODE_POS))
		else $error("done outside position mode");

	c_locked: cover property (position_lock_out);
	c_match: cover property (speed_match_out);
	c_done: cover property (position_done_out && $past(live_q));
endmodule : servo_io_chk

bind servo_io_function_logic servo_io_chk i_servo_io_chk (.*);

/* File: testbench/tb.sv */
`include "servo_io_defs.svh"

// ----------------------------------------
// servo io bench
// ----------------------------------------
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0, sys_rst = 1, clk_en = 1, avs_read = 0, avs_write = 0;
	logic [6:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata;
	logic avs_waitrequest, cmd_pulse_in, fb_pulse_in, cgo = 0, fgo = 0, cbusy, fbusy;
	logic emergency_halt_in = 0, clear_deviation_in = 0, speed_limit_source_sel = 0;
	logic pulse_cmd_block = 0, origin_capture_in = 0, prop_only_loop_in = 0;
	logic power_ok_in = 1, fault_in = 0, servo_on_in = 0, cmd_dir_in = 0, fb_dir_in = 0;
	logic [1:0] preset_speed_sel = 0, preset_torque_sel = 0;
	logic signed [15:0] speed_cmd_in = 0, motor_speed_in = 0, filt_speed_in = 0;
	logic signed [15:0] speed_ref_in = 0, drive_speed_out;
	logic [15:0] speed_limit_out, preset_speed_out, preset_torque_out;
	logic position_lock_out, p_only_loop_out, ready_out, rotation_detect_out;
	logic zero_speed_out, speed_match_out, position_done_out;
	logic [7:0] pn = 0;
	logic [15:0] fv [4] = '{16'h00FF, 16'h0100, 16'hFF00, 16'hFF01};
	logic [15:0] mv [4] = '{16'h0120, 16'h0121, 16'h00E0, 16'h00E1};
	int err_count = 0, checks_done = 0, cyc = 0;

	servo_io_function_logic i_servo_io_function_logic (.*);
	host_pulse_src i_host_pulse_src (.core_clk, .sys_rst, .go(cgo), .n(pn),
		.pulse(cmd_pulse_in), .busy(cbusy));
	host_pulse_src i_host_pulse_src_fb (.core_clk, .sys_rst, .go(fgo), .n(pn),
		.pulse(fb_pulse_in), .busy(fbusy));

	always #5 core_clk = ~core_clk;

	// verdict and end of run
	task end_of_test;
		if (err_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk

	// one bus cycle, held until waitrequest is seen low at a rising edge
	task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (n >= 40)
			chk(0, 1);
	endtask : acc

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1, a, d, q);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(0, a, 0, q);
		chk(q, e);
	endtask : rd

	task wt;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : wt

	// pulse train on command (f=0) or feedback (f=1)
	task automatic pl(input logic f, input logic [7:0] k);
		@(posedge core_clk);
		cgo <= !f;
		fgo <= f;
		pn <= k;
		@(posedge core_clk);
		cgo <= 0;
		fgo <= 0;
		do wt(); while (cbusy || fbusy);
		wt();
	endtask : pl

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 0;
		for (int i = 0; i < 18; i++)
			if (i != 1) rd(7'(i * 4), 0);
		for (int i = 2; i < 12; i++)
			wr(7'(i * 4), 32'h1000 + i);
		wr(`OFS_ROT_THR, 32'h100);
		wr(`OFS_ZERO_BAND, 32'h20);
		wr(`OFS_MATCH_BAND, 32'h20);
		wr(`OFS_DONE_RANGE, 32'h4);
		rd(`OFS_LIM_SRC1, 32'h1003);
		wr(7'h50, 32'h1234);
		rd(7'h50, 0);
		wr(`OFS_DEVIATION, 32'h5);
		rd(`OFS_DEVIATION, 0);
		// speed codes, limit source, loop kind
		wr(`OFS_CTRL, 1);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			preset_speed_sel <= 2'(i);
			speed_limit_source_sel <= i[0];
			prop_only_loop_in <= i[1];
			wt();
			chk(preset_speed_out, 16'h1004 + i);
			chk(speed_limit_out, 16'h1002 + i[0]);
			chk(p_only_loop_out, i[1]);
		end
		// torque codes, speed inputs ignored here
		wr(`OFS_CTRL, 2);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			preset_torque_sel <= 2'(i);
			preset_speed_sel <= 2'(i);
			wt();
			chk(preset_torque_out, 16'h1008 + i);
			chk(preset_speed_out, 16'h1007);
			chk(p_only_loop_out, 0);
		end
		// status thresholds at their edges
		wr(`OFS_CTRL, 1);
		@(posedge core_clk);
		speed_ref_in <= 16'sh0100;
		speed_cmd_in <= 16'sh0100;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			filt_speed_in <= fv[i];
			motor_speed_in <= mv[i];
			wt();
			chk(rotation_detect_out, 4'b0110 >> i & 1);
			chk(zero_speed_out, 4'b1101 >> i & 1);
			chk(speed_match_out, 4'b1000 >> i & 1);
		end
		// deviation, completion, inhibit, origin, clear
		wr(`OFS_CTRL, 0);
		wt();
		chk(speed_match_out, 0);
		pl(0, 5);
		rd(`OFS_DEVIATION, 5);
		chk(position_done_out, 0);
		pl(1, 2);
		rd(`OFS_DEVIATION, 3);
		rd(`OFS_POSITION, 2);
		chk(position_done_out, 1);
		@(posedge core_clk);
		pulse_cmd_block <= 1;
		pl(0, 3);
		rd(`OFS_DEVIATION, 3);
		pulse_cmd_block <= 0;
		// position source not pulse: command pulses ignored
		wr(`OFS_CTRL, 4);
		pl(0, 2);
		rd(`OFS_DEVIATION, 3);
		wr(`OFS_CTRL, 0);
		@(posedge core_clk);
		origin_capture_in <= 1;
		@(posedge core_clk);
		origin_capture_in <= 0;
		rd(`OFS_POSITION, 0);
		clear_deviation_in <= 1;
		@(posedge core_clk);
		clear_deviation_in <= 0;
		rd(`OFS_DEVIATION, 0);
		// halt ramp, lock and release; ready conditions
		speed_cmd_in <= 16'sh0035;
		wt();
		chk(drive_speed_out, 16'h0035);
		chk(ready_out, 1);
		// clock enable low freezes the speed demand
		@(posedge core_clk);
		clk_en <= 0;
		speed_cmd_in <= 16'sh0044;
		wt();
		chk(drive_speed_out, 16'h0035);
		@(posedge core_clk);
		clk_en <= 1;
		speed_cmd_in <= 16'sh0035;
		@(posedge core_clk);
		emergency_halt_in <= 1;
		for (int i = 0; i < 20 && position_lock_out !== 1'b1; i++)
			wt();
		chk(position_lock_out, 1);
		chk(drive_speed_out, 0);
		chk(ready_out, 0);
		@(posedge core_clk);
		emergency_halt_in <= 0;
		servo_on_in <= 1;
		wt();
		chk(position_lock_out, 0);
		chk(drive_speed_out, 16'h0035);
		chk(ready_out, 0);
		@(posedge core_clk);
		servo_on_in <= 0;
		fault_in <= 1;
		wt();
		chk(ready_out, 0);
		end_of_test();
	end
endmodule : tb
